// File: rtl/caf_filter_match.sv
// One acceptance filter compared against a received identifier
`timescale 1ns/1ps
`default_nettype none
module caf_filter_match (
  input wire logic [15:0] filt_std,
  input wire logic [15:0] filt_ext,
  input wire logic [15:0] msk_std,
  input wire logic [15:0] msk_ext,
  input wire logic msk_ok,
  input wire logic enable,
  input wire logic rx_ext,
  input wire logic [10:0] rx_sid,
  input wire logic [17:0] rx_eid,
  output logic hit
);
  wire [10:0] sid_diff;
  wire [17:0] eid_diff;
  wire sid_eq;
  wire eid_eq;
  wire type_ok;
  wire id_ok;

  // Masked compare: a mask bit of 0 makes the bit a don't-care
  assign sid_diff = (filt_std[caf_pkg::SID_MSB:caf_pkg::SID_LSB] ^ rx_sid)
    & msk_std[caf_pkg::SID_MSB:caf_pkg::SID_LSB];
  assign eid_diff = ({filt_std[caf_pkg::EID_HI_MSB:0], filt_ext} ^ rx_eid)
    & {msk_std[caf_pkg::EID_HI_MSB:0], msk_ext};
  assign sid_eq = (sid_diff == 11'h000);
  assign eid_eq = (eid_diff == 18'h00000);
  // Frame type only counts when the mask asks for it
  assign type_ok = !msk_std[caf_pkg::TYPE_BIT]
    || (filt_std[caf_pkg::TYPE_BIT] == rx_ext);
  // Standard frames carry no extended bits, so only the STANDARD_IDENTIFIER_BITS is compared
  assign id_ok = rx_ext ? (sid_eq && eid_eq) : sid_eq;
  assign hit = enable && msk_ok && type_ok && id_ok;
endmodule
`default_nettype wire

// File: rtl/caf_pkg.sv
// Constants shared by the acceptance filter block
package caf_pkg;
  localparam int NUM_FILT = 16;
  localparam int NUM_MASK = 3;
  localparam int NUM_BUF = 32;
  localparam int ADDR_W = 8;
  // Register byte addresses
  localparam logic [7:0] ADDR_FILT_STD = 8'h00;
  localparam logic [7:0] ADDR_FILT_EXT = 8'h40;
  localparam logic [7:0] ADDR_SEL_LO = 8'h80;
  localparam logic [7:0] ADDR_SEL_HI = 8'h84;
  localparam logic [7:0] ADDR_MSK_STD = 8'h88;
  localparam logic [7:0] ADDR_MSK_EXT = 8'h94;
  localparam logic [7:0] ADDR_ENABLE = 8'ha0;
  localparam logic [7:0] ADDR_BUF_PTR = 8'ha4;
  localparam logic [7:0] ADDR_FULL_LO = 8'hb4;
  localparam logic [7:0] ADDR_FULL_HI = 8'hb8;
  localparam logic [7:0] ADDR_STATUS = 8'hbc;
  localparam logic [7:0] ADDR_END = 8'hc0;
  // Field positions in the standard identifier words
  localparam int SID_MSB = 15;
  localparam int SID_LSB = 5;
  localparam int TYPE_BIT = 3;
  localparam int EID_HI_MSB = 1;
  // Bits 4 and 2 are unimplemented
  localparam logic [15:0] STD_WMASK = 16'hffeb;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [15:0] ENABLE_RST = 16'hffff;
  localparam logic [3:0] PTR_FIFO = 4'hf;
  localparam logic [1:0] SEL_RESERVED = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: rtl/caf_top.sv
// Acceptance filter bank with AXI4-Lite register access
// How it works
// - Sixteen filters, 0 to 15, each with standard and extended id words.
// - Filter standard id bits 15-5 give required received STANDARD_IDENTIFIER_BITS values.
// - Filter extended id: bits 17:16 in std word 1-0, rest in ext word.
// - Mask mode bit 1: filter type bit 3 picks extended or standard only.
// - Mask mode bit 0: type bit ignored, matching id of either frame hits.
// - Two-bit selector per filter picks mask 0, 1 or 2; 11 reserved.
// - Selectors for filters 0-7 in first register, 8-15 in second.
// - Mask standard bits 15-5: 1 compares that bit, 0 don't care.
// - Mask extended 18 bits: 1 compares that bit, 0 ignores it.
// - Filter takes part only when enabled; all enables reset to 1.
// - Hit routes frame to filter's 4-bit buffer pointer; 1111 means FIFO.
// - Frame written to a buffer sets its full flag; software clears it.
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module caf_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_valid,
  input wire logic rx_ext,
  input wire logic [10:0] rx_sid,
  input wire logic [17:0] rx_eid,
  output logic acc_valid,
  output logic [3:0] acc_filter,
  output logic [3:0] acc_buffer,
  output logic acc_to_fifo,
  output logic [31:0] rx_full
);
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [7:0] aw_addr_r;
  logic [15:0] w_data_r;
  logic [1:0] w_strb_r;
  logic [15:0] filt_std_r [caf_pkg::NUM_FILT];
  logic [15:0] filt_ext_r [caf_pkg::NUM_FILT];
  logic [15:0] msk_std_r [caf_pkg::NUM_MASK];
  logic [15:0] msk_ext_r [caf_pkg::NUM_MASK];
  logic [15:0] sel_r [2];
  logic [15:0] ptr_r [4];
  logic [15:0] enable_r;
  logic [31:0] full_r, full_nxt;
  logic acc_valid_r, acc_fifo_r, last_valid_r;
  logic [3:0] acc_filt_r, acc_buf_r;

  wire wr_fire;
  wire [7:0] wa;
  wire [15:0] wmask;
  wire [15:0] wmerge;
  wire wr_filt_std, wr_filt_ext, wr_msk_std, wr_msk_ext;
  wire [3:0] wr_idx;
  wire [7:0] wa_msk_std, wa_msk_ext;
  wire [1:0] wr_msk_std_idx, wr_msk_ext_idx;
  wire wr_ok;
  wire [7:0] ra;
  wire [3:0] rd_idx;
  wire [7:0] ra_msk_std, ra_msk_ext;
  logic [15:0] rd_word;
  logic rd_ok;
  logic [15:0] hit_vec;
  logic any_hit;
  logic [3:0] win_idx;
  wire [3:0] win_ptr;
  wire [31:0] full_set, full_clr;
  wire accept;

  // Write executes once both address and data are held
  assign wr_fire = !awready_r && !wready_r && !bvalid_r;
  assign wa = aw_addr_r;
  assign wmask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign wr_idx = wa[5:2];
  assign wr_filt_std = (wa < caf_pkg::ADDR_FILT_EXT);
  assign wr_filt_ext = (wa >= caf_pkg::ADDR_FILT_EXT)
    && (wa < caf_pkg::ADDR_SEL_LO);
  assign wa_msk_std = wa - caf_pkg::ADDR_MSK_STD;
  assign wa_msk_ext = wa - caf_pkg::ADDR_MSK_EXT;
  assign wr_msk_std_idx = wa_msk_std[3:2];
  assign wr_msk_ext_idx = wa_msk_ext[3:2];
  assign wr_msk_std = (wa >= caf_pkg::ADDR_MSK_STD)
    && (wa < caf_pkg::ADDR_MSK_EXT);
  assign wr_msk_ext = (wa >= caf_pkg::ADDR_MSK_EXT)
    && (wa < caf_pkg::ADDR_ENABLE);
  assign wr_ok = (wa < caf_pkg::ADDR_STATUS);

  // Read decode
  assign ra = s_axi_araddr;
  assign rd_idx = ra[5:2];
  assign ra_msk_std = ra - caf_pkg::ADDR_MSK_STD;
  assign ra_msk_ext = ra - caf_pkg::ADDR_MSK_EXT;

  always_comb begin
    rd_word = 16'h0000;
    rd_ok = (ra < caf_pkg::ADDR_END);
    if (ra < caf_pkg::ADDR_FILT_EXT) begin
      rd_word = filt_std_r[rd_idx];
    end else if (ra < caf_pkg::ADDR_SEL_LO) begin
      rd_word = filt_ext_r[rd_idx];
    end else if (ra < caf_pkg::ADDR_MSK_STD) begin
      rd_word = sel_r[ra[2]];
    end else if (ra < caf_pkg::ADDR_MSK_EXT) begin
      rd_word = msk_std_r[ra_msk_std[3:2]];
    end else if (ra < caf_pkg::ADDR_ENABLE) begin
      rd_word = msk_ext_r[ra_msk_ext[3:2]];
    end else if (ra < caf_pkg::ADDR_BUF_PTR) begin
      rd_word = enable_r;
    end else if (ra < caf_pkg::ADDR_FULL_LO) begin
      rd_word = ptr_r[ra[3:2] - 2'h1];
    end else if (ra < caf_pkg::ADDR_FULL_HI) begin
      rd_word = full_r[15:0];
    end else if (ra < caf_pkg::ADDR_STATUS) begin
      rd_word = full_r[31:16];
    end else begin
      rd_word = {7'h00, last_valid_r, acc_fifo_r, 3'h0, acc_buf_r[3:0]}
        | {4'h0, acc_filt_r, 8'h00};
    end
  end

  // AXI4-Lite handshakes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= caf_pkg::RESP_OKAY;
      aw_addr_r <= 8'h00;
      w_data_r <= 16'h0000;
      w_strb_r <= 2'h0;
    end else if (ce) begin
      if (s_axi_awvalid && awready_r) begin
        awready_r <= 1'b0;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
        wready_r <= 1'b0;
        w_data_r <= s_axi_wdata[15:0];
        w_strb_r <= s_axi_wstrb[1:0];
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? caf_pkg::RESP_OKAY : caf_pkg::RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= caf_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && arready_r) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= {16'h0000, rd_word};
        rresp_r <= rd_ok ? caf_pkg::RESP_OKAY : caf_pkg::RESP_SLVERR;
      end
      if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // Configuration registers
  assign wmerge = w_data_r & wmask;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < caf_pkg::NUM_FILT; i++) begin
        filt_std_r[i] <= caf_pkg::REG_RST;
        filt_ext_r[i] <= caf_pkg::REG_RST;
      end
      for (int i = 0; i < caf_pkg::NUM_MASK; i++) begin
        msk_std_r[i] <= caf_pkg::REG_RST;
        msk_ext_r[i] <= caf_pkg::REG_RST;
      end
      for (int i = 0; i < 4; i++) begin
        ptr_r[i] <= caf_pkg::REG_RST;
      end
      sel_r[0] <= caf_pkg::REG_RST;
      sel_r[1] <= caf_pkg::REG_RST;
      enable_r <= caf_pkg::ENABLE_RST;
    end else if (ce && wr_fire) begin
      if (wr_filt_std) begin
        filt_std_r[wr_idx] <= ((filt_std_r[wr_idx] & ~wmask) | wmerge)
          & caf_pkg::STD_WMASK;
      end
      if (wr_filt_ext) begin
        filt_ext_r[wr_idx] <= (filt_ext_r[wr_idx] & ~wmask) | wmerge;
      end
      if (wr_msk_std && wr_msk_std_idx != 2'h3) begin
        msk_std_r[wr_msk_std_idx] <= ((msk_std_r[wr_msk_std_idx] & ~wmask)
          | wmerge) & caf_pkg::STD_WMASK;
      end
      if (wr_msk_ext && wr_msk_ext_idx != 2'h3) begin
        msk_ext_r[wr_msk_ext_idx] <= (msk_ext_r[wr_msk_ext_idx] & ~wmask)
          | wmerge;
      end
      if (wa == caf_pkg::ADDR_SEL_LO || wa == caf_pkg::ADDR_SEL_HI) begin
        sel_r[wa[2]] <= (sel_r[wa[2]] & ~wmask) | wmerge;
      end
      if (wa == caf_pkg::ADDR_ENABLE) begin
        enable_r <= (enable_r & ~wmask) | wmerge;
      end
      if (wa >= caf_pkg::ADDR_BUF_PTR && wa < caf_pkg::ADDR_FULL_LO) begin
        ptr_r[wa[3:2] - 2'h1] <= (ptr_r[wa[3:2] - 2'h1] & ~wmask) | wmerge;
      end
    end
  end

  // Per-filter mask selection and compare
  for (genvar k = 0; k < caf_pkg::NUM_FILT; k++) begin : g_filt
    wire [1:0] code;
    wire [15:0] m_std;
    wire [15:0] m_ext;
    assign code = sel_r[k / 8][2 * (k % 8) +: 2];
    // Reserved code 11 never hits, so a stray setting fails safe
    assign m_std = msk_std_r[(code == caf_pkg::SEL_RESERVED) ? 2'h0 : code];
    assign m_ext = msk_ext_r[(code == caf_pkg::SEL_RESERVED) ? 2'h0 : code];
    caf_filter_match u_match (
      .filt_std(filt_std_r[k]),
      .filt_ext(filt_ext_r[k]),
      .msk_std(m_std),
      .msk_ext(m_ext),
      .msk_ok(code != caf_pkg::SEL_RESERVED),
      .enable(enable_r[k]),
      .rx_ext(rx_ext),
      .rx_sid(rx_sid),
      .rx_eid(rx_eid),
      .hit(hit_vec[k])
    );
  end

  // Lowest-numbered hit wins
  always_comb begin
    win_idx = 4'h0;
    any_hit = 1'b0;
    for (int i = caf_pkg::NUM_FILT - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        win_idx = 4'(i);
        any_hit = 1'b1;
      end
    end
  end

  assign win_ptr = ptr_r[win_idx[3:2]][4 * win_idx[1:0] +: 4];
  assign accept = rx_valid && any_hit;
  assign full_set = (accept && win_ptr != caf_pkg::PTR_FIFO)
    ? (32'h00000001 << win_ptr) : 32'h00000000;
  // Writing 0 to a byte-enabled bit clears it
  assign full_clr = {
    (wr_fire && wa == caf_pkg::ADDR_FULL_HI) ? (wmask & ~w_data_r) : 16'h0,
    (wr_fire && wa == caf_pkg::ADDR_FULL_LO) ? (wmask & ~w_data_r) : 16'h0};
  // A new frame beats a clear in the same cycle
  assign full_nxt = (full_r & ~full_clr) | full_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      full_r <= 32'h00000000;
      acc_valid_r <= 1'b0;
      acc_filt_r <= 4'h0;
      acc_buf_r <= 4'h0;
      acc_fifo_r <= 1'b0;
      last_valid_r <= 1'b0;
    end else if (ce) begin
      full_r <= full_nxt;
      acc_valid_r <= accept;
      if (accept) begin
        acc_filt_r <= win_idx;
        acc_buf_r <= win_ptr;
        acc_fifo_r <= (win_ptr == caf_pkg::PTR_FIFO);
        last_valid_r <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign acc_valid = acc_valid_r;
  assign acc_filter = acc_filt_r;
  assign acc_buffer = acc_buf_r;
  assign acc_to_fifo = acc_fifo_r;
  assign rx_full = full_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_frame_hit;
    ce && accept;
  endsequence

  chk_hit_reported: assert property (
    s_frame_hit |=> acc_valid_r && acc_filt_r == $past(win_idx))
    else $error("accepted frame not reported");
  chk_lowest_wins: assert property (
    (ce && rx_valid && hit_vec[0]) |=> acc_filt_r == 4'h0)
    else $error("lower filter did not win");
  chk_disabled_quiet: assert property (
    !enable_r[0] |-> !hit_vec[0])
    else $error("disabled filter hit");
  chk_reserved_quiet: assert property (
    sel_r[0][1:0] == caf_pkg::SEL_RESERVED |-> !hit_vec[0])
    else $error("reserved mask code hit");
  chk_full_set: assert property (
    (s_frame_hit and win_ptr != caf_pkg::PTR_FIFO)
      |=> full_r[$past(win_ptr)])
    else $error("full flag not set");
  chk_fifo_route: assert property (
    (s_frame_hit and win_ptr == caf_pkg::PTR_FIFO)
      |=> acc_to_fifo && full_r == $past(full_r & ~full_clr))
    else $error("fifo routing wrong");
  chk_unimpl_zero: assert property (
    (filt_std_r[0] & ~caf_pkg::STD_WMASK) == 16'h0000
      && (msk_std_r[0] & ~caf_pkg::STD_WMASK) == 16'h0000)
    else $error("unimplemented bit set");
  chk_type_mode: assert property (
    (rx_valid && sel_r[0][1:0] == 2'h0 && msk_std_r[0][caf_pkg::TYPE_BIT]
      && filt_std_r[0][caf_pkg::TYPE_BIT] != rx_ext) |-> !hit_vec[0])
    else $error("frame type mismatch hit");
  chk_sid_compare: assert property (
    (sel_r[0][1:0] == 2'h0 && |((filt_std_r[0][15:5] ^ rx_sid)
      & msk_std_r[0][15:5])) |-> !hit_vec[0])
    else $error("masked sid mismatch hit");
  chk_write_resp: assert property (
    (ce && wr_fire) |=> bvalid_r)
    else $error("write response missing");
endmodule
`default_nettype wire

// File: sim/caf_rx_source.sv
// Protocol engine stand-in that hands received identifiers to the filter
`timescale 1ns/1ps
`default_nettype none
module caf_rx_source (
  input wire logic aclk,
  output logic rx_valid,
  output logic rx_ext,
  output logic [10:0] rx_sid,
  output logic [17:0] rx_eid
);
  initial begin
    rx_valid = 1'b0;
    rx_ext = 1'b0;
    rx_sid = 11'h000;
    rx_eid = 18'h00000;
  end
  // One identifier per call; calls may follow each other every cycle
  task automatic send(input logic e, input logic [10:0] s,
                      input logic [17:0] x);
    @(posedge aclk);
    rx_valid <= 1'b1;
    rx_ext <= e;
    rx_sid <= s;
    rx_eid <= x;
  endtask
  // Outside frames the id lines mean nothing, so they toggle rather than hold
  task automatic idle();
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_ext <= ~rx_ext;
    rx_sid <= ~rx_sid;
    rx_eid <= ~rx_eid;
  endtask
endmodule
`default_nettype wire

// File: sim/tb_can_acceptance_filter_match.sv
// Self-checking bench for the acceptance filter bank
`timescale 1ns/1ps
`default_nettype none
module tb_can_acceptance_filter_match;
  logic aclk, aresetn, ce;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rx_full;
  logic [3:0] wstrb, acc_filter, acc_buffer;
  logic [1:0] bresp, rresp;
  logic rx_valid, rx_ext, acc_valid, acc_to_fifo;
  logic [10:0] rx_sid;
  logic [17:0] rx_eid;
  int failures = 0;
  int check_count = 0;
  integer seed = 32'h3e9b34a9;
  logic [15:0] fstd [16], fext [16], mstd [3], mext [3], selw [2], ptrw [4];
  logic [15:0] en;
  logic [31:0] full;
  logic [40:0] exp_a;
  logic [40:0] aq [$];
  logic [33:0] rq [$];

  caf_top DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_valid(rx_valid),
    .rx_ext(rx_ext), .rx_sid(rx_sid), .rx_eid(rx_eid),
    .acc_valid(acc_valid), .acc_filter(acc_filter), .acc_buffer(acc_buffer),
    .acc_to_fifo(acc_to_fifo), .rx_full(rx_full));
  caf_rx_source src (.aclk(aclk), .rx_valid(rx_valid), .rx_ext(rx_ext),
    .rx_sid(rx_sid), .rx_eid(rx_eid));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  function automatic logic [15:0] rnd();
    return 16'($random(seed));
  endfunction

  task automatic check(input string name, input logic [63:0] seen,
                       input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic axi_wr(input int off, input logic [15:0] v,
                        input logic [1:0] resp);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    awaddr <= off[7:0];
    wdata <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    check("bresp", bresp, resp);
  endtask

  task automatic axi_rd(input int off, input logic [15:0] v,
                        input logic [1:0] resp);
    rq.push_back({resp, 16'h0000, v});
    @(posedge aclk);
    araddr <= off[7:0];
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask

  task automatic wr_chk(input int off, input logic [15:0] v,
                        input logic [15:0] msk);
    axi_wr(off, v, caf_pkg::RESP_OKAY);
    axi_rd(off, v & msk, caf_pkg::RESP_OKAY);
  endtask

  // Lowest enabled filter whose selected mask lets the identifier through
  function automatic int winner(logic e, logic [10:0] s, logic [17:0] x);
    logic [15:0] ms, fs;
    logic [1:0] k;
    for (int f = 0; f < 16; f++) begin
      fs = fstd[f];
      k = selw[f / 8][2 * (f % 8) +: 2];
      ms = mstd[k];
      if (k != caf_pkg::SEL_RESERVED && en[f]
          && ((fs[15:5] ^ s) & ms[15:5]) == 11'h000
          && (!e || (({fs[1:0], fext[f]} ^ x) & {ms[1:0], mext[k]}) == 0)
          && (!ms[3] || fs[3] == e)) return f;
    end
    return -1;
  endfunction

  task automatic frame(input logic e, input logic [10:0] s,
                       input logic [17:0] x);
    int w;
    logic [3:0] p;
    w = winner(e, s, x);
    if (w >= 0) begin
      p = ptrw[w / 4][4 * (w % 4) +: 4];
      if (p != caf_pkg::PTR_FIFO) full[p] = 1'b1;
      aq.push_back({w[3:0], p, p == caf_pkg::PTR_FIFO, full});
    end
    src.send(e, s, x);
  endtask

  task automatic config_round();
    logic [15:0] v;
    int k;
    for (int f = 0; f < 16; f++) begin
      v = rnd();
      wr_chk(caf_pkg::ADDR_FILT_STD + 4 * f, v, caf_pkg::STD_WMASK);
      fstd[f] = v & caf_pkg::STD_WMASK;
      v = rnd();
      wr_chk(caf_pkg::ADDR_FILT_EXT + 4 * f, v, 16'hffff);
      fext[f] = v;
    end
    for (int m = 0; m < 3; m++) begin
      v = rnd() & rnd() & 16'hffe0 | rnd() & 16'h000b;
      wr_chk(caf_pkg::ADDR_MSK_STD + 4 * m, v, caf_pkg::STD_WMASK);
      mstd[m] = v & caf_pkg::STD_WMASK;
      v = rnd() & rnd() & rnd();
      wr_chk(caf_pkg::ADDR_MSK_EXT + 4 * m, v, 16'hffff);
      mext[m] = v;
    end
    for (int i = 0; i < 4; i++) begin
      ptrw[i] = rnd();
      wr_chk(caf_pkg::ADDR_BUF_PTR + 4 * i, ptrw[i], 16'hffff);
      if (i < 2) begin
        selw[i] = rnd();
        wr_chk(caf_pkg::ADDR_SEL_LO + 4 * i, selw[i], 16'hffff);
      end
    end
    en = rnd() | rnd();
    wr_chk(caf_pkg::ADDR_ENABLE, en, 16'hffff);
    // Near-miss identifiers: at most one bit flipped in the standard id and one in the extended id of a stored filter
    for (int n = 0; n < 40; n++) begin
      k = rnd() % 16;
      frame(1'(rnd()), fstd[k][15:5] ^ (11'h001 << rnd() % 16),
            {fstd[k][1:0], fext[k]} ^ (18'h00001 << rnd() % 32));
    end
    src.idle();
    axi_rd(caf_pkg::ADDR_FULL_LO, full[15:0], caf_pkg::RESP_OKAY);
  endtask

  always @(posedge aclk) begin
    if (aresetn && rvalid && rready)
      check("read", {rresp, rdata}, rq.pop_front());
    if (acc_valid && aq.size() == 0)
      check("acc_valid", 1'b1, 1'b0);
    else if (acc_valid) begin
      exp_a = aq.pop_front();
      check("filter", acc_filter, exp_a[40:37]);
      check("route", {acc_buffer, acc_to_fifo}, exp_a[36:32]);
      check("full", rx_full, exp_a[31:0]);
    end
  end

  initial begin
    repeat (20000) @(posedge aclk);
    check("watchdog", 1'b1, 1'b0);
    complete_run();
  end

  initial begin
    {aresetn, awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
    {arvalid, rready, full} = '0;
    ce = 1'b1;
    wstrb = 4'h3;
    en = caf_pkg::ENABLE_RST;
    for (int i = 0; i < 16; i++) begin
      fstd[i] = 16'h0000;
      fext[i] = 16'h0000;
      mstd[i % 3] = 16'h0000;
      mext[i % 3] = 16'h0000;
      selw[i % 2] = 16'h0000;
      ptrw[i % 4] = 16'h0000;
    end
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(caf_pkg::ADDR_ENABLE, 16'hffff, caf_pkg::RESP_OKAY);
    // Reset leaves every filter open, so filter 0 must win
    frame(1'b1, 11'h5a5, 18'h2a5a5);
    src.idle();
    // Let the accept pulse drop first, since a low enable freezes it
    @(posedge aclk);
    ce <= 1'b0;
    // Would hit every open filter, but a frozen block must not take it
    src.send(1'b0, 11'h123, 18'h00000);
    src.idle();
    ce <= 1'b1;
    axi_wr(caf_pkg::ADDR_STATUS, 16'hffff, caf_pkg::RESP_SLVERR);
    // Past the map the status word still shows: filter 0, buffer 0, valid
    axi_rd(caf_pkg::ADDR_END, 16'h0100, caf_pkg::RESP_SLVERR);
    repeat (4) config_round();
    axi_wr(caf_pkg::ADDR_FULL_LO, 16'h0000, caf_pkg::RESP_OKAY);
    full[15:0] = 16'h0000;
    axi_rd(caf_pkg::ADDR_FULL_LO, 16'h0000, caf_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    check("pending", aq.size() + rq.size(), 0);
    complete_run();
  end
endmodule
`default_nettype wire
